// *** src/ddr_guard_pkg.sv ***
package ddr_guard_pkg;

  // system clock and the memory clock derived from it
  localparam int CLK_PERIOD_PS = 10000;
  localparam int CK_DIV = 2;

  // nanosecond minimums, rounded up to whole system clocks
  localparam int BANK_TO_BANK_ACTIVATE_GAP_NS = 10;
  localparam int BANK_TO_BANK_ACTIVATE_GAP_CYC =
    (BANK_TO_BANK_ACTIVATE_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int WRITE_RECOVERY_CYC =
    (WRITE_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFRESH_BUSY_NS = 70;
  localparam int REFRESH_BUSY_CYC =
    (REFRESH_BUSY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SELFREFRESH_EXIT_NONREAD_GAP_NS = 75;
  localparam int SELFREFRESH_EXIT_NONREAD_GAP_CYC =
    (SELFREFRESH_EXIT_NONREAD_GAP_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int ACTIVATE_TO_PRECHARGE_MIN_NS = 40;
  localparam int ACTIVATE_TO_PRECHARGE_MIN_CYC =
    (ACTIVATE_TO_PRECHARGE_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;

  // memory clock cycle figures
  localparam int WRITE_LATENCY_TCK = 1;
  localparam int WRITE_TO_READ_GAP_TCK = 2;
  localparam int SELFREFRESH_EXIT_READ_GAP_TCK = 200;
  localparam int SELFREFRESH_EXIT_READ_GAP_CYC =
    SELFREFRESH_EXIT_READ_GAP_TCK * CK_DIV;

  // refresh limits, longest times rounded down
  localparam int AVG_REFRESH_SPACING_SMALL_NS = 15600;
  localparam int AVG_REFRESH_SPACING_LARGE_NS = 7800;
  localparam int MAX_REFRESH_SPACING_SMALL_NS = 140600;
  localparam int MAX_REFRESH_SPACING_LARGE_NS = 70300;
  localparam int AVG_REFRESH_SPACING_LARGE_CYC =
    AVG_REFRESH_SPACING_LARGE_NS * 1000 / CLK_PERIOD_PS;
  localparam int MAX_REFRESH_SPACING_LARGE_CYC =
    MAX_REFRESH_SPACING_LARGE_NS * 1000 / CLK_PERIOD_PS;
  localparam int AVG_REFRESH_SPACING_SMALL_CYC =
    AVG_REFRESH_SPACING_SMALL_NS * 1000 / CLK_PERIOD_PS;
  localparam int MAX_REFRESH_SPACING_SMALL_CYC =
    MAX_REFRESH_SPACING_SMALL_NS * 1000 / CLK_PERIOD_PS;
  localparam int RETENTION_PERIOD_MS = 64;
  localparam logic signed [4:0] REFRESH_BATCH_MAX = 5'sh08;

  localparam int TIMER_W = 16;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_ACTIVATE = 3'h1,
    OP_READ = 3'h2,
    OP_WRITE = 3'h3,
    OP_PRECHARGE = 3'h4,
    OP_REFRESH = 3'h5,
    OP_SELF_ENTER = 3'h6,
    OP_SELF_EXIT = 3'h7
  } op_t;

  typedef enum logic [0:0] {
    ST_RUN = 1'h0,
    ST_SELF = 1'h1
  } state_t;

endpackage

// *** src/gap_timer.sv ***
`timescale 1ns/1ps
module gap_timer #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // load and status
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic [W-1:0] o_left,
  output logic o_done
);

  logic [W-1:0] left_r;
  logic [W-1:0] left_nxt;

  always_comb
  begin
    left_nxt = left_r;
    if (i_load)
      left_nxt = i_count;
    else if (left_r != '0)
      left_nxt = left_r - W'(1);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      left_r <= '0;
    else
      left_r <= left_nxt;
  end

  assign o_left = left_r;
  assign o_done = (left_r == '0);

endmodule // gap_timer

// *** src/ddr_timing_guard.sv ***
`timescale 1ns/1ps
module ddr_timing_guard #(
  parameter int BURST_LEN = 4,
  parameter int LANES = 9,
  parameter int AVG_REFRESH_CYC =
    ddr_guard_pkg::AVG_REFRESH_SPACING_LARGE_CYC,
  parameter int MAX_REFRESH_CYC =
    ddr_guard_pkg::MAX_REFRESH_SPACING_LARGE_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // command request
  input wire logic i_cmd_valid,
  input wire ddr_guard_pkg::op_t i_cmd_op,
  input wire logic i_cmd_rank,
  input wire logic [1:0] i_cmd_bank,
  input wire logic [12:0] i_cmd_addr,
  output logic o_cmd_ready,
  // status
  output logic o_self_refresh,
  output logic signed [4:0] o_refresh_owed,
  // memory pins
  output logic o_ck,
  output logic o_ck_n,
  output logic o_cke,
  output logic [1:0] o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [1:0] o_ba,
  output logic [12:0] o_addr,
  output logic [LANES-1:0] o_dqs_o,
  output logic [LANES-1:0] o_dqs_oe
);

  localparam int TW = ddr_guard_pkg::TIMER_W;
  localparam int DIV = ddr_guard_pkg::CK_DIV;
  localparam int BURST_TCK = BURST_LEN / 2;
  localparam int WR_DATA_END_CYC =
    (ddr_guard_pkg::WRITE_LATENCY_TCK + BURST_TCK) * DIV;
  localparam int WTR_CYC = WR_DATA_END_CYC
    + ddr_guard_pkg::WRITE_TO_READ_GAP_TCK * DIV;
  localparam int RD_PRE_CYC = BURST_TCK * DIV;
  localparam int WR_PRE_CYC =
    WR_DATA_END_CYC + ddr_guard_pkg::WRITE_RECOVERY_CYC;
  localparam int DQS_CYC = WR_DATA_END_CYC + DIV;

  if (!(BURST_LEN == 2 || BURST_LEN == 4 || BURST_LEN == 8))
  begin : g_bad_burst
    $error("burst length must be 2, 4 or 8");
  end
  if (AVG_REFRESH_CYC < 2 || MAX_REFRESH_CYC >= (1 << TW)
      || AVG_REFRESH_CYC >= MAX_REFRESH_CYC)
  begin : g_bad_refresh
    $error("refresh counts out of range");
  end

  // memory clock divider and command slot
  logic ck_r;
  logic ck_nxt;
  logic slot;

  always_comb
  begin
    ck_nxt = ~ck_r;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ck_r <= 1'b0;
    else
      ck_r <= ck_nxt;
  end

  // pins change as ck falls, so the device samples them half a clock later
  assign slot = ck_r;
  assign o_ck = ck_r;
  assign o_ck_n = ~ck_r;

  // timers
  logic rrd_done, wtr_done, rfc_done, xsnr_done, xsrd_done;
  logic refi_done, refc_done;
  logic ld_rrd, ld_wtr, ld_rfc, ld_xs, ld_refc;
  logic [7:0] ld_ras;
  logic [TW-1:0] ras_left [8];

  gap_timer #(.W(TW)) u_rrd (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(ld_rrd),
    .i_count(TW'(ddr_guard_pkg::BANK_TO_BANK_ACTIVATE_GAP_CYC)),
    .o_left(), .o_done(rrd_done));
  // done shows a cycle after the count runs out, so load one less to
  // open the gap on the exact slot instead of one slot late
  gap_timer #(.W(TW)) u_wtr (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(ld_wtr),
    .i_count(TW'(WTR_CYC - 1)), .o_left(), .o_done(wtr_done));
  gap_timer #(.W(TW)) u_rfc (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(ld_rfc),
    .i_count(TW'(ddr_guard_pkg::REFRESH_BUSY_CYC)),
    .o_left(), .o_done(rfc_done));
  gap_timer #(.W(TW)) u_xsnr (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(ld_xs),
    .i_count(TW'(ddr_guard_pkg::SELFREFRESH_EXIT_NONREAD_GAP_CYC - 1)),
    .o_left(), .o_done(xsnr_done));
  gap_timer #(.W(TW)) u_xsrd (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(ld_xs),
    .i_count(TW'(ddr_guard_pkg::SELFREFRESH_EXIT_READ_GAP_CYC - 1)),
    .o_left(), .o_done(xsrd_done));
  gap_timer #(.W(TW)) u_refi (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(refi_done),
    .i_count(TW'(AVG_REFRESH_CYC - 1)), .o_left(), .o_done(refi_done));
  // margin of two slots keeps the forced refresh inside the longest spacing
  gap_timer #(.W(TW)) u_refc (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(ld_refc),
    .i_count(TW'(MAX_REFRESH_CYC - 2 * DIV)),
    .o_left(), .o_done(refc_done));

  for (genvar b = 0; b < 8; b++)
  begin : g_bank
    gap_timer #(.W(TW)) u_ras (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_load(ld_ras[b]),
      .i_count(TW'(ddr_guard_pkg::ACTIVATE_TO_PRECHARGE_MIN_CYC)),
      .o_left(ras_left[b]), .o_done());
  end

  // scheduler state
  ddr_guard_pkg::state_t state_r, state_nxt;
  logic signed [4:0] owed_r, owed_nxt;
  logic cke_r, cke_nxt;
  logic [1:0] cs_n_r, cs_n_nxt;
  logic [2:0] rcw_r, rcw_nxt;
  logic [1:0] ba_r, ba_nxt;
  logic [12:0] addr_r, addr_nxt;
  logic [TW-1:0] dqs_cnt_r, dqs_cnt_nxt;

  logic [2:0] bidx;
  logic autopre, user_ok, force_ref, auto_take, take, ref_tick;
  ddr_guard_pkg::op_t op;

  assign bidx = {i_cmd_rank, i_cmd_bank};
  assign autopre = i_cmd_addr[10];
  assign ref_tick = refi_done && (state_r == ddr_guard_pkg::ST_RUN);

  always_comb
  begin
    user_ok = 1'b0;
    if (state_r == ddr_guard_pkg::ST_SELF)
      user_ok = (i_cmd_op == ddr_guard_pkg::OP_SELF_EXIT);
    else
      unique case (i_cmd_op)
        ddr_guard_pkg::OP_NOP: user_ok = 1'b1;
        ddr_guard_pkg::OP_ACTIVATE:
          user_ok = rrd_done && rfc_done && xsnr_done;
        ddr_guard_pkg::OP_READ:
          user_ok = wtr_done && xsrd_done && rfc_done
            && (!autopre || ras_left[bidx] <= TW'(RD_PRE_CYC));
        ddr_guard_pkg::OP_WRITE:
          user_ok = xsnr_done && rfc_done
            && (!autopre || ras_left[bidx] <= TW'(WR_PRE_CYC));
        ddr_guard_pkg::OP_PRECHARGE:
          user_ok = xsnr_done && rfc_done && ras_left[bidx] == '0;
        ddr_guard_pkg::OP_REFRESH:
          user_ok = xsnr_done && rfc_done
            && owed_r > -ddr_guard_pkg::REFRESH_BATCH_MAX;
        ddr_guard_pkg::OP_SELF_ENTER:
          user_ok = xsnr_done && rfc_done;
        ddr_guard_pkg::OP_SELF_EXIT: user_ok = 1'b0;
      endcase
  end

  always_comb
  begin
    // owed count at eight or the longest spacing near: stall the user
    force_ref = (state_r == ddr_guard_pkg::ST_RUN)
      && (owed_r >= ddr_guard_pkg::REFRESH_BATCH_MAX
      || refc_done);
    auto_take = slot && rfc_done && xsnr_done && (force_ref
      || (state_r == ddr_guard_pkg::ST_RUN && owed_r > 5'sh00
      && !i_cmd_valid));
    o_cmd_ready = slot && user_ok && !force_ref && !auto_take;
    take = i_cmd_valid && o_cmd_ready;
    op = auto_take ? ddr_guard_pkg::OP_REFRESH
      : (take ? i_cmd_op : ddr_guard_pkg::OP_NOP);
  end

  always_comb
  begin
    state_nxt = state_r;
    owed_nxt = owed_r;
    cke_nxt = cke_r;
    cs_n_nxt = cs_n_r;
    rcw_nxt = rcw_r;
    ba_nxt = ba_r;
    addr_nxt = addr_r;
    dqs_cnt_nxt = (dqs_cnt_r != '0) ? dqs_cnt_r - TW'(1) : dqs_cnt_r;
    ld_rrd = 1'b0;
    ld_wtr = 1'b0;
    ld_rfc = 1'b0;
    ld_xs = 1'b0;
    ld_refc = 1'b0;
    ld_ras = '0;
    if (ref_tick && owed_r < ddr_guard_pkg::REFRESH_BATCH_MAX)
      owed_nxt = owed_r + 5'sh01;
    if (slot)
    begin
      cs_n_nxt = 2'h3;
      rcw_nxt = 3'h7;
      ba_nxt = i_cmd_bank;
      addr_nxt = i_cmd_addr;
      unique case (op)
        ddr_guard_pkg::OP_NOP: ;
        ddr_guard_pkg::OP_ACTIVATE:
        begin
          cs_n_nxt = i_cmd_rank ? 2'h1 : 2'h2;
          rcw_nxt = 3'h3;
          ld_rrd = 1'b1;
          ld_ras[bidx] = 1'b1;
        end
        ddr_guard_pkg::OP_READ:
        begin
          cs_n_nxt = i_cmd_rank ? 2'h1 : 2'h2;
          rcw_nxt = 3'h5;
        end
        ddr_guard_pkg::OP_WRITE:
        begin
          cs_n_nxt = i_cmd_rank ? 2'h1 : 2'h2;
          rcw_nxt = 3'h4;
          ld_wtr = 1'b1;
          dqs_cnt_nxt = TW'(DQS_CYC);
        end
        ddr_guard_pkg::OP_PRECHARGE:
        begin
          cs_n_nxt = i_cmd_rank ? 2'h1 : 2'h2;
          rcw_nxt = 3'h2;
        end
        ddr_guard_pkg::OP_REFRESH:
        begin
          cs_n_nxt = 2'h0;
          rcw_nxt = 3'h1;
          ld_rfc = 1'b1;
          ld_refc = 1'b1;
          owed_nxt = ref_tick ? owed_r : owed_r - 5'sh01;
        end
        ddr_guard_pkg::OP_SELF_ENTER:
        begin
          cs_n_nxt = 2'h0;
          rcw_nxt = 3'h1;
          cke_nxt = 1'b0;
          state_nxt = ddr_guard_pkg::ST_SELF;
        end
        ddr_guard_pkg::OP_SELF_EXIT:
        begin
          cke_nxt = 1'b1;
          state_nxt = ddr_guard_pkg::ST_RUN;
          ld_xs = 1'b1;
          ld_refc = 1'b1;
        end
      endcase
    end
    // the device keeps its own rows fresh while self refresh lasts
    if (state_r == ddr_guard_pkg::ST_SELF)
      owed_nxt = 5'sh00;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_r <= ddr_guard_pkg::ST_RUN;
      owed_r <= 5'sh00;
      cke_r <= 1'b1;
      cs_n_r <= 2'h3;
      rcw_r <= 3'h7;
      ba_r <= 2'h0;
      addr_r <= 13'h0000;
      dqs_cnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      owed_r <= owed_nxt;
      cke_r <= cke_nxt;
      cs_n_r <= cs_n_nxt;
      rcw_r <= rcw_nxt;
      ba_r <= ba_nxt;
      addr_r <= addr_nxt;
      dqs_cnt_r <= dqs_cnt_nxt;
    end
  end

  // strobe low from the command edge, toggling through the burst
  logic dqs_toggle;
  assign dqs_toggle = dqs_cnt_r > TW'(DIV)
    && dqs_cnt_r <= TW'(WR_DATA_END_CYC - DIV + DIV);
  assign o_dqs_oe = {LANES{dqs_cnt_r != '0}};
  assign o_dqs_o = {LANES{dqs_toggle && ck_r}};

  assign o_cke = cke_r;
  assign o_cs_n = cs_n_r;
  assign {o_ras_n, o_cas_n, o_we_n} = rcw_r;
  assign o_ba = ba_r;
  assign o_addr = addr_r;
  assign o_self_refresh = (state_r == ddr_guard_pkg::ST_SELF);
  assign o_refresh_owed = owed_r;

endmodule // ddr_timing_guard

// *** tb/ddr_timing_guard_chk.sv ***
`timescale 1ns/1ps
module ddr_timing_guard_chk #(
  parameter int MAX_REFRESH_CYC = 7030
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // command request
  input wire logic i_cmd_valid,
  input wire ddr_guard_pkg::op_t i_cmd_op,
  input wire logic i_cmd_rank,
  input wire logic [1:0] i_cmd_bank,
  input wire logic o_cmd_ready,
  // status and pins
  input wire logic o_self_refresh,
  input wire logic signed [4:0] o_refresh_owed,
  input wire logic o_ck,
  input wire logic o_cke,
  input wire logic [1:0] o_cs_n,
  input wire logic o_ras_n,
  input wire logic o_cas_n,
  input wire logic o_we_n,
  input wire logic [1:0] o_ba
);
  localparam int NR_GAP = ddr_guard_pkg::SELFREFRESH_EXIT_NONREAD_GAP_CYC;
  localparam int RD_GAP = ddr_guard_pkg::SELFREFRESH_EXIT_READ_GAP_CYC;
  localparam logic signed [4:0] LIM = ddr_guard_pkg::REFRESH_BATCH_MAX;
  logic tk, ref_pins;
  logic [15:0] exit_r, exit_nxt, gap_r, gap_nxt;
  assign tk = i_cmd_valid && o_cmd_ready;
  assign ref_pins = o_cs_n == 2'h0 && {o_ras_n, o_cas_n, o_we_n} == 3'h1;
  // cycles since self refresh exit, saturating
  always_comb
  begin
    exit_nxt = (exit_r == 16'hFFFF) ? exit_r : exit_r + 16'h1;
    if (tk && i_cmd_op == ddr_guard_pkg::OP_SELF_EXIT)
      exit_nxt = 16'h1;
    gap_nxt = (ref_pins || o_self_refresh) ? 16'h0 : gap_r + 16'h1;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      exit_r <= 16'hFFFF;
      gap_r <= 16'h0;
    end
    else
    begin
      exit_r <= exit_nxt;
      gap_r <= gap_nxt;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_ready_slot: assert property (
    o_cmd_ready |-> o_ck && !$past(o_ck)) else $error("ready off slot");
  chk_act_pins: assert property (
    tk && i_cmd_op == ddr_guard_pkg::OP_ACTIVATE |=>
    {o_ras_n, o_cas_n, o_we_n} == 3'h3 && o_ba == $past(i_cmd_bank)
    && !o_cs_n[$past(i_cmd_rank)]) else $error("bad activate pins");
  chk_wtr_gap: assert property (
    tk && i_cmd_op == ddr_guard_pkg::OP_WRITE |=>
    (!(tk && i_cmd_op == ddr_guard_pkg::OP_READ))[*8])
    else $error("read too soon after write");
  chk_exit_nonread: assert property (
    tk && !(i_cmd_op inside {ddr_guard_pkg::OP_READ, ddr_guard_pkg::OP_NOP})
    |-> exit_r >= NR_GAP) else $error("command too soon after exit");
  chk_exit_read: assert property (
    tk && i_cmd_op == ddr_guard_pkg::OP_READ |-> exit_r >= RD_GAP)
    else $error("read too soon after exit");
  chk_cke_refresh: assert property (
    ref_pins && o_cke |=> o_cke[*6]) else $error("cke dropped in refresh");
  chk_owed_limit: assert property (
    o_refresh_owed <= LIM && !(tk && o_refresh_owed == -LIM
    && i_cmd_op == ddr_guard_pkg::OP_REFRESH)) else $error("owed out of range");
  chk_refresh_max: assert property (
    gap_r <= MAX_REFRESH_CYC) else $error("refresh spacing too long");
  chk_self_only: assert property (
    o_self_refresh && o_cmd_ready |-> i_cmd_op == ddr_guard_pkg::OP_SELF_EXIT)
    else $error("command taken in self refresh");
  cov_write: cover property (tk && i_cmd_op == ddr_guard_pkg::OP_WRITE);
  cov_refresh: cover property (ref_pins && o_cke);
  cov_owed_max: cover property (o_refresh_owed == LIM);
endmodule // ddr_timing_guard_chk

bind ddr_timing_guard ddr_timing_guard_chk #(
  .MAX_REFRESH_CYC(MAX_REFRESH_CYC)
) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid),
  .i_cmd_op(i_cmd_op), .i_cmd_rank(i_cmd_rank), .i_cmd_bank(i_cmd_bank),
  .o_cmd_ready(o_cmd_ready), .o_self_refresh(o_self_refresh),
  .o_refresh_owed(o_refresh_owed), .o_ck(o_ck), .o_cke(o_cke),
  .o_cs_n(o_cs_n), .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n),
  .o_ba(o_ba)
);

// *** tb/ddr_dimm_model.sv ***
`timescale 1ns/1ps
module ddr_dimm_model #(
  parameter int LANES = 9
) (
  // memory pins
  input wire logic i_ck,
  input wire logic i_cke,
  input wire logic [1:0] i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [LANES-1:0] i_dqs,
  input wire logic [LANES-1:0] i_dqs_oe,
  // observations
  output int o_viol,
  output int o_refs,
  output int o_ticks,
  output logic [LANES-1:0] o_lanes
);
  realtime t_act = -1.0e6, t_wr = -1.0e6, t_exit = -1.0e6, t_ref = -1.0e6;
  logic in_self = 1'b0;
  logic [2:0] op;
  assign op = {i_ras_n, i_cas_n, i_we_n};
  initial
  begin
    o_viol = 0;
    o_refs = 0;
    o_ticks = 0;
    o_lanes = '0;
  end
  always @(posedge i_ck)
  begin
    if (in_self && i_cke)
      t_exit = $realtime;
    in_self = in_self && !i_cke;
    if ($realtime - t_ref < 70.0 && !i_cke)
      o_viol++;
    if (i_cs_n != 2'h3)
    begin
      if (op == 3'h1)
        in_self = !i_cke;
      if (op == 3'h1 && i_cke)
        o_refs++;
      if (op == 3'h1 && i_cke)
        t_ref = $realtime;
      if (op == 3'h3 && $realtime - t_act < 10.0)
        o_viol++;
      if (op == 3'h4 && i_dqs_oe != '1)
        o_viol++;
      // burst end plus two memory clocks at 20 ns
      if (op == 3'h5 && $realtime - t_wr < 100.0)
        o_viol++;
      if ($realtime - t_exit < ((op == 3'h5) ? 4000.0 : 75.0))
        o_viol++;
      if (op == 3'h3)
        t_act = $realtime;
      if (op == 3'h4)
        t_wr = $realtime;
    end
  end
  // own refresh timer, needs no commands while in self refresh
  always
  begin
    #1000;
    if (in_self)
      o_ticks++;
  end
  always @(i_dqs)
    for (int i = 0; i < LANES; i++)
      if (i_dqs_oe[i] && i_dqs[i])
        o_lanes[i] = 1'b1;
endmodule // ddr_dimm_model

// *** tb/test_ddr_timing_guard.sv ***
`timescale 1ns/1ps
module test_ddr_timing_guard;
  localparam int WTR = (ddr_guard_pkg::WRITE_LATENCY_TCK + 4 / 2
    + ddr_guard_pkg::WRITE_TO_READ_GAP_TCK) * ddr_guard_pkg::CK_DIV;
  logic i_clk, i_sys_rst, i_cmd_valid, i_cmd_rank;
  ddr_guard_pkg::op_t i_cmd_op;
  logic [1:0] i_cmd_bank, o_cs_n, o_ba;
  logic [12:0] i_cmd_addr, o_addr;
  logic o_cmd_ready, o_self_refresh, o_ck, o_ck_n, o_cke;
  logic o_ras_n, o_cas_n, o_we_n;
  logic signed [4:0] o_refresh_owed;
  logic [8:0] o_dqs_o, o_dqs_oe, lanes;
  int viol, refs, ticks, n_fail = 0, check_count = 0, cyc = 0;
  logic [12:0] cmd_addr;
  ddr_timing_guard #(.AVG_REFRESH_CYC(40), .MAX_REFRESH_CYC(400)) dut_u (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op), .i_cmd_rank(i_cmd_rank), .i_cmd_bank(i_cmd_bank),
    .i_cmd_addr(i_cmd_addr), .o_cmd_ready(o_cmd_ready),
    .o_self_refresh(o_self_refresh), .o_refresh_owed(o_refresh_owed),
    .o_ck(o_ck), .o_ck_n(o_ck_n), .o_cke(o_cke), .o_cs_n(o_cs_n),
    .o_ras_n(o_ras_n), .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_ba(o_ba),
    .o_addr(o_addr), .o_dqs_o(o_dqs_o), .o_dqs_oe(o_dqs_oe));
  ddr_dimm_model u_dev (.i_ck(o_ck), .i_cke(o_cke), .i_cs_n(o_cs_n),
    .i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_we_n(o_we_n), .i_dqs(o_dqs_o),
    .i_dqs_oe(o_dqs_oe), .o_viol(viol), .o_refs(refs), .o_ticks(ticks),
    .o_lanes(lanes));
  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // holds the request until taken or lim edges pass; at is -1 if refused
  task automatic cmd(input ddr_guard_pkg::op_t op, input logic [1:0] bank,
      input int lim, output int at);
    int n;
    n = 0;
    at = -1;
    @(posedge i_clk);
    #1;
    i_cmd_valid = 1'b1;
    i_cmd_op = op;
    i_cmd_bank = bank;
    i_cmd_rank = bank[0];
    i_cmd_addr = cmd_addr;
    while (at < 0 && n < lim)
    begin
      @(posedge i_clk);
      if (o_cmd_ready === 1'b1)
        at = cyc;
      n++;
    end
    #1;
    i_cmd_valid = 1'b0;
  endtask
  task automatic t_act();
    int a, b;
    cmd(ddr_guard_pkg::OP_ACTIVATE, 2'h0, 20, a);
    cmd(ddr_guard_pkg::OP_ACTIVATE, 2'h1, 20, b);
    check(16'(a >= 0 && b - a >= 2), 16'h1);
    check(16'({o_ras_n, o_cas_n, o_we_n, o_ba, o_cs_n}), 16'h0035);
    check(16'(o_ck ^ o_ck_n), 16'h0001);
    $display("t_act end");
  endtask
  // read with auto precharge right after activate, then a precharge
  task automatic t_ap();
    int a, b, c;
    cmd(ddr_guard_pkg::OP_ACTIVATE, 2'h3, 20, a);
    cmd_addr = 13'h0412;
    cmd(ddr_guard_pkg::OP_READ, 2'h3, 20, b);
    check(16'(o_addr), 16'h0412);
    cmd_addr = 13'h0012;
    cmd(ddr_guard_pkg::OP_PRECHARGE, 2'h3, 20, c);
    check(16'(a >= 0 && b - a == 2 && c - a >= 4), 16'h1);
    $display("t_ap end");
  endtask
  task automatic t_wr_rd();
    int a, b;
    cmd(ddr_guard_pkg::OP_WRITE, 2'h0, 20, a);
    cmd(ddr_guard_pkg::OP_READ, 2'h0, 40, b);
    check(16'(b - a), 16'(WTR));
    check(16'(lanes), 16'h01FF);
    $display("t_wr_rd end");
  endtask
  task automatic t_refresh();
    int r0, mx, at, k;
    r0 = refs;
    idle(400);
    check(16'(refs - r0 >= 9), 16'h1);
    mx = 0;
    r0 = refs;
    i_cmd_valid = 1'b1;
    i_cmd_op = ddr_guard_pkg::OP_NOP;
    repeat (360)
    begin
      @(posedge i_clk);
      if (o_refresh_owed > mx)
        mx = o_refresh_owed;
    end
    #1;
    i_cmd_valid = 1'b0;
    check(16'(mx), 16'h0008);
    check(16'(refs > r0), 16'h1);
    k = 0;
    at = 0;
    while (at >= 0 && k < 40)
    begin
      cmd(ddr_guard_pkg::OP_REFRESH, 2'h0, 24, at);
      k++;
    end
    check(16'(o_refresh_owed), 16'hFFF8);
    $display("t_refresh end");
  endtask
  task automatic t_self();
    int e, a, b, t0;
    cmd(ddr_guard_pkg::OP_SELF_ENTER, 2'h0, 40, a);
    idle(2);
    check(16'({o_self_refresh, o_cke}), 16'h0002);
    t0 = ticks;
    cmd(ddr_guard_pkg::OP_ACTIVATE, 2'h0, 300, a);
    check(16'(a), 16'hFFFF);
    check(16'(ticks > t0), 16'h1);
    cmd(ddr_guard_pkg::OP_SELF_EXIT, 2'h0, 20, e);
    cmd(ddr_guard_pkg::OP_ACTIVATE, 2'h2, 40, a);
    cmd(ddr_guard_pkg::OP_READ, 2'h2, 500, b);
    check(16'(a - e >= 8 && b - e >= 400), 16'h1);
    $display("t_self end");
  endtask
  initial
  begin
    i_sys_rst = 1'b1;
    i_cmd_valid = 1'b0;
    i_cmd_op = ddr_guard_pkg::OP_NOP;
    i_cmd_rank = 1'b0;
    i_cmd_bank = 2'h0;
    i_cmd_addr = 13'h0000;
    cmd_addr = 13'h0012;
    idle(5);
    i_sys_rst = 1'b0;
    t_act();
    t_ap();
    t_wr_rd();
    t_refresh();
    t_self();
    check(16'(viol), 16'h0);
    test_done();
  end
endmodule // test_ddr_timing_guard
